// ==== src/smsc_regs.svh ====
// register offsets, field positions, reset values and codes of the mode switch control
// assumes inclusion by bare name from the package and the testbench
`ifndef SMSC_REGS_SVH
`define SMSC_REGS_SVH
// byte offsets on the register bus
`define SMSC_OFS_CTRL      4'h0
`define SMSC_OFS_STATUS    4'h4
`define SMSC_OFS_COUNTER   4'h8
`define SMSC_OFS_TXINFO    4'hC
// control register fields
`define SMSC_CTRL_TEACH    0
`define SMSC_CTRL_KEYNEW   1
`define SMSC_CTRL_MODEWE   2
`define SMSC_CTRL_MODE_LO  4
`define SMSC_CTRL_MODE_HI  5
// field widths and reset values
`define SMSC_CNT_W         24
`define SMSC_CNT_RST       24'h00_0000
`define SMSC_CNT_ONE       24'h00_0001
`define SMSC_CNT16_MASK    24'h00_FFFF
`define SMSC_PRESS_RST     3'h0
`define SMSC_PRESS_ONE     3'h1
`define SMSC_PRESS_RESET   3'h7
`define SMSC_NIP_RST       4'h0
// teach-in info values
`define SMSC_TI_TYPE_PB    1'b1
`define SMSC_ROCKER_A      1'b0
`define SMSC_ROCKER_B      1'b1
// security level format: [7:6] auth code, [5:3] cipher, [2:1] counter size, [0] counter sent
`define SMSC_SLF_NONE      8'h00
`define SMSC_SLF_IMPLICIT  8'hCA
`define SMSC_SLF_EXPLICIT  8'hCD
`endif

// ==== src/smsc_pkg.sv ====
// types shared by the mode switch control
// assumes smsc_regs.svh is on the include path
package smsc_pkg;
   `include "smsc_regs.svh"
   typedef enum logic [1:0] {MD_NORMAL, MD_IMPLICIT, MD_EXPLICIT} smsc_mode_e;
   typedef enum logic [2:0] {FR_LP_NORMAL, FR_LP_SECURE, FR_ROCKER_ENC, FR_TEACH1, FR_TEACH2} smsc_frame_e;
   typedef enum logic [2:0] {CB_NONE, CB_TWO_CH, CB_TWO_X, CB_THREE, CB_FOUR} smsc_combo_e;
   typedef struct packed {
      logic                   valid;      // one-cycle request to the radio
      smsc_frame_e            kind;
      logic                   pressed;    // bow pressed (1) or released (0)
      logic [3:0]             nipples;    // {b_on, b_off, a_on, a_off}
      logic                   counterIncl;
      logic [`SMSC_CNT_W-1:0] counter;
      logic                   tiType;
      logic                   rocker;
      logic [7:0]             security_level_format;
   } smsc_frame_s;
endpackage : smsc_pkg

// ==== src/smsc_mode_ctrl.sv ====
// mode switch, teach-in and frame selection for a self-powered pushbutton transmitter
// assumes async nipple/bow/rocker pins, one 200 MHz clock, Avalon-MM register access
//
// What this block does; RULE2, RULE3 and RULE5 are kept by the receiver model
// RULE1 - implicit mode: counter sent only in teach-in, never in data telegrams
// RULE2 - receiver advances its counter copy on every received telegram
// RULE3 - receiver searches a window of future counters, resyncs on match
// RULE4 - explicit mode: current counter placed in every secure data telegram
// RULE5 - receiver accepts only counters above last accepted, no window search
// RULE6 - teach-in sent on two/three nipple sequence or contactless request; the code serves a contactless request only in implicit or explicit mode
// RULE7 - teach-in type is 1 (pushbutton); info 0 rocker A, 1 rocker B
// RULE8 - button teach-in reports the channel with both nipples pressed
// RULE9 - contactless teach-in reports actuated rocker; A if both or none
// RULE10 - implicit format: 24-bit auth, variable cipher, 16-bit counter, not sent
// RULE11 - explicit format: 24-bit auth, variable cipher, 24-bit counter, sent
// RULE12 - teach-in split: first part on press, second on next release
// RULE13 - exactly one sub-telegram per teach-in actuation
// RULE14 - two same-channel: implicit; three: explicit; four: normal with reset
// RULE15 - four nipples held: normal mode on first bow press
// RULE16 - three nipples, first press/release: teach-in only if already explicit
// RULE17 - second press of two/three sequence: enter mode, send teach-in part one
// RULE18 - second teach-in part on next release regardless of nipples
// RULE19 - mode change only if combination held for the whole sequence
// RULE20 - four nipples through seven press/release cycles: factory reset
// RULE21 - factory reset restores all settings to default except custom message; the code resets only the mode and the pending contactless request
// RULE22 - frame kind: normal low-power, secure low-power, or encrypted rocker
// RULE23 - counter starts at zero, plus one per telegram, zero on key change
// RULE24 - no data telegram while two, three or four nipples pressed
// RULE25 - after reset and factory reset the mode is normal
// RULE26 - changed nipple set abandons a sequence; second teach-in part exempt
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module smsc_mode_ctrl
   import smsc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // user side pins
   input  wire logic        channel_a_off_contact,
   input  wire logic        channel_a_on_contact,
   input  wire logic        channel_b_off_contact,
   input  wire logic        channel_b_on_contact,
   input  wire logic        bowPressed,
   input  wire logic        rockerAUsed,
   input  wire logic        rockerBUsed,
   // radio side
   output smsc_frame_s      txFrame,
   // register bus
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);

   //---------------------------------------------------------------
   // pin synchroniser
   //---------------------------------------------------------------
   logic [6:0] pinMeta_q;
   logic [6:0] pinSync_q;
   logic       bowDly_q;

   // two flops per pin plus a delay flop on the bow; only the second stage and the bow delay feed logic
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pinMeta_q <= 7'h00;
         pinSync_q <= 7'h00;
         bowDly_q  <= 1'b0;
      end else begin
         pinMeta_q <= {rockerBUsed, rockerAUsed, bowPressed, channel_b_on_contact,
                       channel_b_off_contact, channel_a_on_contact, channel_a_off_contact};
         pinSync_q <= pinMeta_q;
         bowDly_q  <= pinSync_q[4];
      end
   end

   logic [3:0] nip;
   logic       pressEv;
   logic       relEv;
   assign nip     = pinSync_q[3:0];
   assign pressEv = pinSync_q[4] & ~bowDly_q;
   assign relEv   = ~pinSync_q[4] & bowDly_q;

   //---------------------------------------------------------------
   // combination classifier
   //---------------------------------------------------------------
   smsc_combo_e cls;
   logic [2:0]  nipCnt;
   logic        bothA;
   logic        bothB;
   assign bothA  = nip[0] & nip[1];
   assign bothB  = nip[2] & nip[3];
   assign nipCnt = {2'b00, nip[0]} + {2'b00, nip[1]} + {2'b00, nip[2]} + {2'b00, nip[3]};

   // sort the pressed set into the mode control classes
   always_comb begin
      cls = CB_NONE;
      case (nipCnt)
         3'd2:    cls = (bothA | bothB) ? CB_TWO_CH : CB_TWO_X;   // RULE14
         3'd3:    cls = CB_THREE;                                 // RULE14
         3'd4:    cls = CB_FOUR;                                  // RULE14
         default: cls = CB_NONE;
      endcase
   end

   //---------------------------------------------------------------
   // sequence decoder
   //---------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_TI2} smsc_state_e;
   smsc_state_e   state_q;
   smsc_state_e   state_d;
   smsc_mode_e    mode_q;
   smsc_mode_e    modeUse;
   logic [3:0]    seqSet_q;
   logic [2:0]    pressCnt_q;
   logic [2:0]    pressCnt_d;
   logic          tiPend_q;
   logic          tiRocker_q;
   logic          tiFromBus;
   logic          teachReqWr;
   logic          keyNewWr;
   logic          modeWr;
   smsc_mode_e    modeWrVal;
   logic          emit;
   smsc_frame_e   emitKind;
   logic          emitRocker;
   logic          modeSet;
   smsc_mode_e    modeNew;
   logic          factory;
   logic          sameSet;
   logic          nfcRocker;
   logic          btnRocker;
   smsc_frame_e   dataKind;

   logic rockerAUsed_s;
   logic rockerBUsed_s;
   assign sameSet   = (nip == seqSet_q);
   assign nfcRocker = (rockerBUsed_s & ~rockerAUsed_s) ? `SMSC_ROCKER_B : `SMSC_ROCKER_A; // RULE9
   assign btnRocker = bothA ? `SMSC_ROCKER_A : `SMSC_ROCKER_B;                              // RULE8
   assign rockerAUsed_s = pinSync_q[5];
   assign rockerBUsed_s = pinSync_q[6];

   // frame kind of a data telegram in the current mode
   always_comb begin
      unique case (mode_q)
         MD_NORMAL:   dataKind = FR_LP_NORMAL;    // RULE22
         MD_IMPLICIT: dataKind = FR_LP_SECURE;    // RULE22
         MD_EXPLICIT: dataKind = FR_ROCKER_ENC;   // RULE22
         default:     dataKind = FR_LP_NORMAL;
      endcase
   end

   // press/release events against the held combination
   always_comb begin
      state_d    = state_q;
      pressCnt_d = pressCnt_q;
      emit       = 1'b0;
      emitKind   = dataKind;
      emitRocker = tiRocker_q;
      modeSet    = 1'b0;
      modeNew    = mode_q;
      factory    = 1'b0;
      tiFromBus  = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (pressEv) begin
               if (cls == CB_NONE) begin
                  emit = 1'b1;
                  if (tiPend_q && mode_q != MD_NORMAL) begin
                     emitKind   = FR_TEACH1;                  // RULE6
                     emitRocker = nfcRocker;                  // RULE9
                     tiFromBus  = 1'b1;
                     state_d    = ST_TI2;                     // RULE12
                  end
               end else begin
                  state_d    = ST_HELD;                       // RULE24
                  pressCnt_d = `SMSC_PRESS_ONE;
                  if (cls == CB_FOUR) begin
                     modeSet = 1'b1;                          // RULE15
                     modeNew = MD_NORMAL;
                  end
               end
            end else if (relEv && cls == CB_NONE) begin
               emit = 1'b1;                                   // RULE24
            end
         end
         ST_HELD: begin
            if (!sameSet) begin
               state_d = ST_IDLE;                             // RULE26 RULE19
            end else if (pressEv) begin
               pressCnt_d = pressCnt_q + `SMSC_PRESS_ONE;
               if ((cls == CB_TWO_CH || cls == CB_THREE) && pressCnt_q == `SMSC_PRESS_ONE) begin
                  modeSet    = 1'b1;                          // RULE17
                  modeNew    = (cls == CB_THREE) ? MD_EXPLICIT : MD_IMPLICIT;
                  emit       = 1'b1;
                  emitKind   = FR_TEACH1;                     // RULE12
                  emitRocker = btnRocker;                     // RULE8
                  state_d    = ST_TI2;
               end
            end else if (relEv) begin
               if (cls == CB_THREE && pressCnt_q == `SMSC_PRESS_ONE && mode_q == MD_EXPLICIT) begin
                  emit       = 1'b1;                          // RULE16
                  emitKind   = FR_TEACH1;
                  emitRocker = btnRocker;
               end
               if (cls == CB_FOUR && pressCnt_q == `SMSC_PRESS_RESET) begin
                  factory = 1'b1;                             // RULE20
                  state_d = ST_IDLE;
               end
            end
         end
         ST_TI2: begin
            if (relEv) begin
               emit     = 1'b1;                               // RULE18
               emitKind = FR_TEACH2;
               state_d  = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // sequence state and press count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q    <= ST_IDLE;
         pressCnt_q <= `SMSC_PRESS_RST;
         seqSet_q   <= `SMSC_NIP_RST;
      end else begin
         state_q    <= state_d;
         pressCnt_q <= pressCnt_d;
         if (state_q == ST_IDLE && pressEv)
            seqSet_q <= nip;
      end
   end

   // operating mode
   assign modeUse = modeSet ? modeNew : mode_q;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_q <= MD_NORMAL;                                 // RULE25
      end else if (factory) begin
         mode_q <= MD_NORMAL;                                 // RULE21 RULE25
      end else if (modeSet) begin
         mode_q <= modeNew;                                   // RULE14
      end else if (modeWr) begin
         mode_q <= modeWrVal;
      end
   end

   // contactless teach-in request; a new request beats its consumption
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tiPend_q <= 1'b0;
      end else if (teachReqWr) begin
         tiPend_q <= 1'b1;                                    // RULE6
      end else if (tiFromBus || factory) begin
         tiPend_q <= 1'b0;
      end
   end

   // rocker of the running teach-in, reused by its second part
   always_ff @(posedge clk) begin
      if (!resetn)
         tiRocker_q <= `SMSC_ROCKER_A;
      else if (emit && emitKind == FR_TEACH1)
         tiRocker_q <= emitRocker;
   end

   //---------------------------------------------------------------
   // rolling counter
   //---------------------------------------------------------------
   logic [`SMSC_CNT_W-1:0] counter_q;
   always_ff @(posedge clk) begin
      if (!resetn)
         counter_q <= `SMSC_CNT_RST;                          // RULE23
      else if (keyNewWr)
         counter_q <= `SMSC_CNT_RST;                          // RULE23
      else if (emit)
         counter_q <= counter_q + `SMSC_CNT_ONE;              // RULE23
   end

   //---------------------------------------------------------------
   // frame request to the radio
   //---------------------------------------------------------------
   smsc_frame_s txFrame_q;
   logic        isTeach;
   assign isTeach = (emitKind == FR_TEACH1) || (emitKind == FR_TEACH2);

   // one request per actuation, no repeats for teach-in
   always_ff @(posedge clk) begin
      if (!resetn) begin
         txFrame_q <= '0;
      end else begin
         txFrame_q.valid       <= emit;                       // RULE13
         txFrame_q.kind        <= emitKind;
         txFrame_q.pressed     <= pressEv;
         txFrame_q.nipples     <= nip;
         txFrame_q.counterIncl <= emit && (isTeach || modeUse == MD_EXPLICIT);   // RULE1 RULE4
         txFrame_q.counter     <= (modeUse == MD_IMPLICIT) ? (counter_q & `SMSC_CNT16_MASK) : counter_q;
         txFrame_q.tiType      <= `SMSC_TI_TYPE_PB;           // RULE7
         txFrame_q.rocker      <= emitRocker;                 // RULE7
         if (!isTeach || modeUse == MD_NORMAL)
            txFrame_q.security_level_format <= `SMSC_SLF_NONE;
         else if (modeUse == MD_IMPLICIT)
            txFrame_q.security_level_format <= `SMSC_SLF_IMPLICIT;              // RULE10
         else
            txFrame_q.security_level_format <= `SMSC_SLF_EXPLICIT;              // RULE11
      end
   end
   assign txFrame = txFrame_q;

   //---------------------------------------------------------------
   // register bus slave, one wait state
   //---------------------------------------------------------------
   logic        wait_q;
   logic [31:0] rdata_q;
   logic        accept;
   assign accept     = (avs_read | avs_write) & ~wait_q;
   assign teachReqWr = accept && avs_write && avs_address == `SMSC_OFS_CTRL && avs_byteenable[0]
                       && avs_writedata[`SMSC_CTRL_TEACH];
   assign keyNewWr   = accept && avs_write && avs_address == `SMSC_OFS_CTRL && avs_byteenable[0]
                       && avs_writedata[`SMSC_CTRL_KEYNEW];
   assign modeWrVal  = smsc_mode_e'(avs_writedata[`SMSC_CTRL_MODE_HI:`SMSC_CTRL_MODE_LO]);
   assign modeWr     = accept && avs_write && avs_address == `SMSC_OFS_CTRL && avs_byteenable[0]
                       && avs_writedata[`SMSC_CTRL_MODEWE]
                       && (avs_writedata[`SMSC_CTRL_MODE_HI:`SMSC_CTRL_MODE_LO] != 2'b11);

   // waitrequest drops for one cycle once a request has stood one cycle
   always_ff @(posedge clk) begin
      if (!resetn)
         wait_q <= 1'b1;
      else
         wait_q <= ~(wait_q & (avs_read | avs_write));
   end

   // read data captured together with the answer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && wait_q) begin
         case (avs_address)
            `SMSC_OFS_CTRL:    rdata_q <= {26'h0, mode_q, 4'h0};
            `SMSC_OFS_STATUS:  rdata_q <= {23'h0, pressCnt_q, state_q, tiPend_q, tiRocker_q, mode_q};
            `SMSC_OFS_COUNTER: rdata_q <= {8'h00, counter_q};
            `SMSC_OFS_TXINFO:  rdata_q <= {16'h0, txFrame_q.security_level_format, txFrame_q.nipples, 1'b0, txFrame_q.kind};
            default:           rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   logic [2:0] nipCntPast_q;
   always_ff @(posedge clk) begin
      if (!resetn)
         nipCntPast_q <= 3'h0;
      else
         nipCntPast_q <= nipCnt;
   end

   sequence seqTeachStart;
      state_q == ST_HELD && sameSet && pressEv && cls == CB_THREE && pressCnt_q == `SMSC_PRESS_ONE;
   endsequence
   sequence seqTeachOut;
      txFrame_q.valid && txFrame_q.kind == FR_TEACH1 && txFrame_q.security_level_format == `SMSC_SLF_EXPLICIT;
   endsequence

   AST_DATA_BLOCKED: assert property (@(posedge clk) disable iff (!resetn)   // RULE24
      txFrame_q.valid && txFrame_q.kind inside {FR_LP_NORMAL, FR_LP_SECURE, FR_ROCKER_ENC} |-> nipCntPast_q < 3'd2)
      else $error("data telegram with a reserved combination");
   AST_IMPL_NO_CNT: assert property (@(posedge clk) disable iff (!resetn)    // RULE1
      txFrame_q.valid && txFrame_q.kind == FR_LP_SECURE |-> !txFrame_q.counterIncl)
      else $error("implicit data carries counter");
   AST_EXPL_CNT: assert property (@(posedge clk) disable iff (!resetn)       // RULE4
      emit && emitKind == FR_ROCKER_ENC |=> txFrame_q.counterIncl && txFrame_q.counter == $past(counter_q))
      else $error("explicit data lacks current counter");
   AST_TI2_FOLLOWS: assert property (@(posedge clk) disable iff (!resetn)    // RULE18
      state_q == ST_TI2 && relEv |=> txFrame_q.valid && txFrame_q.kind == FR_TEACH2 && state_q == ST_IDLE)
      else $error("second teach-in part missing");
   AST_EXPL_ENTRY: assert property (@(posedge clk) disable iff (!resetn)     // RULE17
      seqTeachStart |=> seqTeachOut ##0 mode_q == MD_EXPLICIT)
      else $error("explicit entry without first teach-in part");
   AST_CNT_INC: assert property (@(posedge clk) disable iff (!resetn)        // RULE23
      emit && !keyNewWr |=> counter_q == $past(counter_q) + `SMSC_CNT_ONE)
      else $error("counter not advanced");
   AST_FOUR_NORMAL: assert property (@(posedge clk) disable iff (!resetn)    // RULE15
      state_q == ST_IDLE && pressEv && cls == CB_FOUR |=> mode_q == MD_NORMAL && !txFrame_q.valid)
      else $error("four nipples did not force normal mode");
   AST_ABANDON: assert property (@(posedge clk) disable iff (!resetn)        // RULE26
      state_q == ST_HELD && !sameSet |=> state_q == ST_IDLE && $stable(mode_q))
      else $error("changed set did not abandon");
   AST_FACTORY: assert property (@(posedge clk) disable iff (!resetn)        // RULE20
      state_q == ST_HELD && sameSet && relEv && cls == CB_FOUR && pressCnt_q == `SMSC_PRESS_RESET
      |=> mode_q == MD_NORMAL && !tiPend_q)
      else $error("factory reset not applied");
   AST_TI_FIELDS: assert property (@(posedge clk) disable iff (!resetn)      // RULE7
      txFrame_q.valid && txFrame_q.kind == FR_TEACH1 |-> txFrame_q.tiType == `SMSC_TI_TYPE_PB
      && txFrame_q.counterIncl)
      else $error("teach-in fields wrong");

endmodule : smsc_mode_ctrl

// ==== dv/smsc_rx_model.sv ====
// receiver model: follows the rolling counter of each telegram, counts refused ones
// assumes frames are sampled on the shared clock while valid is high
`timescale 1ns/1ps
module smsc_rx_model
   import smsc_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  resetn,
   input  smsc_frame_s frame,
   output logic [7:0] rejects
);
   logic [15:0] impCnt_q;   // next expected implicit counter
   logic [23:0] expCnt_q;   // last accepted explicit counter
   logic        seen_q;
   // ----------------
   // counter tracking
   // ----------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         impCnt_q <= 16'h0000;
         expCnt_q <= 24'h00_0000;
         seen_q   <= 1'b0;
         rejects  <= 8'h00;
      end else if (frame.valid) begin
         if (frame.kind == FR_TEACH1) begin
            impCnt_q <= frame.counter[15:0] + 16'h0001;
            seen_q   <= 1'b0;
         end else if (frame.kind == FR_LP_SECURE) begin
            // window of eight future values, resync on a match
            if (16'(frame.counter[15:0] - impCnt_q) < 16'h0008) impCnt_q <= frame.counter[15:0] + 16'h0001;
            else rejects <= rejects + 8'h01;
         end else if (frame.kind == FR_ROCKER_ENC) begin
            // carried counter must rise, no window search
            if (seen_q && frame.counter <= expCnt_q) rejects <= rejects + 8'h01;
            else begin
               expCnt_q <= frame.counter;
               seen_q   <= 1'b1;
            end
         end else impCnt_q <= impCnt_q + 16'h0001;
      end
   end
endmodule : smsc_rx_model

// ==== dv/testbench.sv ====
// self-checking bench: nipple and bow sequences, register bus, radio frames
// assumes the slave answers in its own time and a few clocks of pin sync latency
`timescale 1ns/1ps
`include "smsc_regs.svh"
module testbench
   import smsc_pkg::*;
;
   localparam logic [3:0] N3 = 4'h7, N2B = 4'hC, N4 = 4'hF, NX = 4'hB;
   logic        clk = 1'b0, resetn = 1'b0, bow = 1'b0, rkA = 1'b0, rkB = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0]  nip = 4'h0, addr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat, rdata, c;
   logic        waitReq;
   logic [7:0]  rejects;
   smsc_frame_s fr, last;
   int          errors = 0, comparisons = 0, nFr = 0, got;
   smsc_mode_ctrl u_dut (.clk(clk), .resetn(resetn), .channel_a_off_contact(nip[0]),
      .channel_a_on_contact(nip[1]), .channel_b_off_contact(nip[2]), .channel_b_on_contact(nip[3]),
      .bowPressed(bow), .rockerAUsed(rkA), .rockerBUsed(rkB), .txFrame(fr), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
      .avs_readdata(rdata), .avs_waitrequest(waitReq));
   smsc_rx_model u_rx (.clk(clk), .resetn(resetn), .frame(fr), .rejects(rejects));
   // -------------------------
   // clock, frame monitor, tasks
   // -------------------------
   always #2.5 clk = ~clk;
   always @(posedge clk) if (fr.valid === 1'b1) begin
      nFr++;
      last = fr;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk);
      end while (waitReq !== 1'b0);
      rdat = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic act(input logic [3:0] n, input logic b);
      int k;
      @(posedge clk);
      nip <= n;
      repeat (6) @(posedge clk);
      k = nFr;
      bow <= b;
      repeat (10) @(posedge clk);
      got = nFr - k;
   endtask : act
   task automatic fchk(input int n, input smsc_frame_e k);
      chk(got, n);
      if (n > 0) chk(last.kind, k);
   endtask : fchk
   task automatic mode(input smsc_mode_e m);
      bus(1'b0, `SMSC_OFS_STATUS, 32'h0000_0000);
      chk(rdat[1:0], m);
   endtask : mode
   task automatic results;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   // ---------
   // scenarios
   // ---------
   task automatic t_normal;
      mode(MD_NORMAL);
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      act(4'h0, 1'b1);
      fchk(1, FR_LP_NORMAL);
      chk(last.counter, 32'h0000_0000);
      act(4'h0, 1'b0);
      chk(last.counter, 32'h0000_0001);
   endtask : t_normal
   task automatic t_explicit;
      act(N3, 1'b1);
      fchk(0, FR_TEACH1);
      act(N3, 1'b0);
      fchk(0, FR_TEACH1);
      bus(1'b0, `SMSC_OFS_COUNTER, 32'h0000_0000);
      c = rdat;
      act(N3, 1'b1);
      fchk(1, FR_TEACH1);
      chk(last.security_level_format, `SMSC_SLF_EXPLICIT);
      chk({last.tiType, last.rocker}, 2'b10);
      chk(last.counter, c);
      act(4'h0, 1'b0);
      fchk(1, FR_TEACH2);
      mode(MD_EXPLICIT);
      act(4'h0, 1'b1);
      fchk(1, FR_ROCKER_ENC);
      chk({last.counterIncl, last.counter}, {1'b1, c[23:0] + 24'h00_0002});
      act(4'h0, 1'b0);
      act(N3, 1'b1);
      act(N3, 1'b0);
      fchk(1, FR_TEACH1);
      act(N3, 1'b1);
      fchk(1, FR_TEACH1);
      act(N3, 1'b0);
      fchk(1, FR_TEACH2);
   endtask : t_explicit
   task automatic t_implicit;
      act(N2B, 1'b1);
      act(N2B, 1'b0);
      fchk(0, FR_TEACH1);
      act(N2B, 1'b1);
      fchk(1, FR_TEACH1);
      chk({last.security_level_format, last.rocker}, {`SMSC_SLF_IMPLICIT, 1'b1});
      act(4'h0, 1'b0);
      fchk(1, FR_TEACH2);
      mode(MD_IMPLICIT);
      act(4'h0, 1'b1);
      fchk(1, FR_LP_SECURE);
      chk(last.counterIncl, 1'b0);
      act(4'h0, 1'b0);
      act(N3, 1'b1);
      act(NX, 1'b0);
      act(N3, 1'b1);
      fchk(0, FR_TEACH1);
      act(4'h0, 1'b0);
      mode(MD_IMPLICIT);
   endtask : t_implicit
   task automatic t_nfc(input logic a, input logic b);
      rkA <= a;
      rkB <= b;
      bus(1'b1, `SMSC_OFS_CTRL, 32'h0000_0001);
      act(4'h0, 1'b1);
      fchk(1, FR_TEACH1);
      chk(last.rocker, b & ~a);
      act(4'h0, 1'b0);
      fchk(1, FR_TEACH2);
   endtask : t_nfc
   task automatic t_four;
      bus(1'b1, `SMSC_OFS_CTRL, 32'h0000_0001);
      act(N4, 1'b1);
      fchk(0, FR_TEACH1);
      mode(MD_NORMAL);
      act(N4, 1'b0);
      repeat (6) begin
         act(N4, 1'b1);
         act(N4, 1'b0);
      end
      bus(1'b0, `SMSC_OFS_STATUS, 32'h0000_0000);
      chk({rdat[3], rdat[1:0]}, 3'b000);
      bus(1'b1, `SMSC_OFS_CTRL, 32'h0000_0002);
      bus(1'b0, `SMSC_OFS_COUNTER, 32'h0000_0000);
      chk(rdat[23:0], 24'h00_0000);
      bus(1'b1, `SMSC_OFS_CTRL, 32'h0000_0034);
      mode(MD_NORMAL);
      bus(1'b1, `SMSC_OFS_CTRL, 32'h0000_0024);
      bus(1'b0, `SMSC_OFS_CTRL, 32'h0000_0000);
      chk(rdat, 32'h0000_0020);
      act(4'h1, 1'b1);
      fchk(1, FR_ROCKER_ENC);
      chk({last.pressed, last.nipples, last.counterIncl}, 6'h23);
      bus(1'b0, `SMSC_OFS_TXINFO, 32'h0000_0000);
      chk(rdat, 32'h0000_0012);
      act(4'h0, 1'b0);
      fchk(1, FR_ROCKER_ENC);
      chk({last.pressed, last.nipples}, 5'h00);
   endtask : t_four
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_normal();
      t_explicit();
      t_implicit();
      t_nfc(1'b0, 1'b1);
      t_nfc(1'b1, 1'b1);
      t_four();
      chk(rejects, 8'h00);
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
endmodule : testbench
